// ===== hdl/sleep_and_reset_controller.sv
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "sleep_reset_defs.svh"
module sleep_and_reset_controller
	import sleep_reset_pkg::*;
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic [11:0]             paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    por_n,
	input  wire logic                    ext_reset_n,
	input  wire logic                    wdt_reset_req,
	input  wire logic                    bod_trip,
	input  wire logic                    dbg_reset_req,
	input  wire logic                    chip_erase,
	input  wire logic                    debug_link_en,
	input  wire logic                    sleep_instr,
	input  wire logic                    nvm_busy,
	input  wire logic                    irq_any,
	input  wire logic                    irq_async,
	input  wire logic                    irq_rtc,
	output logic                         cpu_halt,
	output logic                         cpu_clk_en,
	output logic                         nvm_clk_en,
	output logic                         periph_clk_en,
	output logic [`NUM_PERIPH-1:0]       periph_gate_en,
	output logic                         rtc_clk_en,
	output logic                         osc_src_en,
	output logic                         osc2m_sel,
	output logic                         ulp_osc_en,
	output logic                         sys_reset_n,
	output logic                         pin_oe_allow,
	output logic [15:0]                  reset_vector,
	output logic                         brownout_detector_en,
	output logic [2:0]                   brownout_threshold_select
);
	localparam int EXT_MIN_CYC = (`EXT_MIN_NS + `CLK_NS - 1) / `CLK_NS;
	localparam int DELAY_CYC = (`RST_DELAY_NS + `CLK_NS - 1) / `CLK_NS;
	localparam int OSC_CYC = (`OSC_START_NS + `CLK_NS - 1) / `CLK_NS;
	localparam int CAL_CYC = (`OSC_CAL_NS + `CLK_NS - 1) / `CLK_NS;

	logic                  ext_s1_ff, ext_s2_ff, wdt_s1_ff, wdt_s2_ff;
	logic [7:0]            ext_cnt_ff;
	logic                  ext_hold_ff;
	logic                  swrst_ff;
	logic                  rel_s1_ff, rel_s2_ff;
	rst_stage_type         stage_ff, nxt_stage;
	logic [7:0]            stage_cnt_ff;
	logic [`NUM_CAUSE-1:0] cause_ff, nxt_cause;
	logic                  reloc_ff, bod_en_ff, rtc_en_ff;
	logic [`MODE_W-1:0]    mode_ff;
	logic [`NUM_PERIPH-1:0] pr_ff;
	pwr_state_type         pst_ff, nxt_pst;
	logic [2:0]            halt_cnt_ff;
	logic [31:0]           rdata_ff;

	wire any_req_n;
	wire core_rst_n;
	wire wake_ok;
	wire wr_en = psel & penable & pwrite;
	wire rd_en = psel & penable & ~pwrite;
	wire hit_ctrl = paddr == `OFS_CTRL;
	wire hit_mode = paddr == `OFS_MODE;
	wire hit_pr = paddr == `OFS_PWR_RED;
	wire hit_cause = paddr == `OFS_CAUSE;
	wire hit_stat = paddr == `OFS_STATUS;
	wire mapped = hit_ctrl | hit_mode | hit_pr | hit_cause | hit_stat;
	sleep_mode_type mode_sel;
	assign mode_sel = sleep_mode_type'(mode_ff);

	// External pin and watchdog request cross into the clock domain first.
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			ext_s1_ff <= 1'b1;
			ext_s2_ff <= 1'b1;
			wdt_s1_ff <= 1'b0;
			wdt_s2_ff <= 1'b0;
		end else begin
			ext_s1_ff <= ext_reset_n;
			ext_s2_ff <= ext_s1_ff;
			wdt_s1_ff <= wdt_reset_req;
			wdt_s2_ff <= wdt_s1_ff;
		end
	end

	// Glitches shorter than the minimum pulse never reach the reset tree.
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			ext_cnt_ff <= 8'h00;
			ext_hold_ff <= 1'b0;
		end else if (ext_s2_ff) begin
			ext_cnt_ff <= 8'h00;
			ext_hold_ff <= 1'b0;
		end else if (ext_cnt_ff >= 8'(EXT_MIN_CYC)) begin
			ext_hold_ff <= 1'b1;
		end else begin
			ext_cnt_ff <= ext_cnt_ff + 8'h01;
		end
	end

	// A watchdog pulse of one or two 2MHz cycles spans many pclk cycles,
	// so the synchronised level is caught reliably.
	assign any_req_n = por_n & ~ext_hold_ff & ~wdt_s2_ff & ~bod_trip
		& ~dbg_reset_req & ~swrst_ff;

	// Assert asynchronously, release through two flops.
	always_ff @(posedge pclk or negedge any_req_n) begin
		if (!any_req_n) begin
			rel_s1_ff <= 1'b0;
			rel_s2_ff <= 1'b0;
		end else begin
			rel_s1_ff <= 1'b1;
			rel_s2_ff <= rel_s1_ff;
		end
	end

	// Any new request clears the sequencer back to its first stage.
	always_comb begin
		nxt_stage = stage_ff;
		case (stage_ff)
			RS_DELAY: if (stage_cnt_ff == 8'(DELAY_CYC - 1)) nxt_stage = RS_OSC;
			RS_OSC: if (stage_cnt_ff == 8'(OSC_CYC - 1)) nxt_stage = RS_CAL;
			RS_CAL: if (stage_cnt_ff == 8'(CAL_CYC - 1)) nxt_stage = RS_RUN;
			default: nxt_stage = RS_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge rel_s2_ff) begin
		if (!rel_s2_ff) begin
			stage_ff <= RS_DELAY;
			stage_cnt_ff <= 8'h00;
		end else begin
			stage_ff <= nxt_stage;
			stage_cnt_ff <= (nxt_stage != stage_ff) ? 8'h00
				: stage_cnt_ff + 8'h01;
		end
	end

	assign core_rst_n = (stage_ff == RS_RUN) & rel_s2_ff;
	assign sys_reset_n = core_rst_n;
	assign pin_oe_allow = core_rst_n;
	assign reset_vector = reloc_ff ? `BOOT_VEC_DEF : `RESET_VEC_DEF;
	assign osc2m_sel = 1'b1;
	assign ulp_osc_en = 1'b1;
	assign brownout_detector_en = bod_en_ff | chip_erase | debug_link_en;
	assign brownout_threshold_select = `BOD_LOWEST;

	// Power-on leaves only the POR flag set, a write of ones to the cause register clears flags; sources set them even during reset.
	// A source event in the cycle of a clearing write wins over the clear.
	always_comb begin
		nxt_cause = cause_ff;
		if (wr_en & hit_cause) nxt_cause = cause_ff & ~pwdata[5:0];
		if (ext_hold_ff) nxt_cause[`CAUSE_EXT] = 1'b1;
		if (wdt_s2_ff) nxt_cause[`CAUSE_WDT] = 1'b1;
		if (bod_trip) nxt_cause[`CAUSE_BOD] = 1'b1;
		if (dbg_reset_req) nxt_cause[`CAUSE_DBG] = 1'b1;
		if (swrst_ff) nxt_cause[`CAUSE_SW] = 1'b1;
	end

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			cause_ff <= 6'h01;
		end else begin
			cause_ff <= nxt_cause;
		end
	end

	// Software reset fires the cycle after the write; the core is halted
	// on that same edge so nothing executes in between. The flop is kept
	// out of the core reset so the pulse lasts a full cycle and the cause
	// flag can catch it.
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			swrst_ff <= 1'b0;
		end else begin
			swrst_ff <= wr_en & hit_ctrl & pwdata[`CTRL_SWRST_BIT]
				& core_rst_n;
		end
	end

	// Configuration registers reset with the core, as I/O registers do.
	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			reloc_ff <= 1'b0;
			bod_en_ff <= 1'b0;
			rtc_en_ff <= 1'b0;
			mode_ff <= 3'h0;
			pr_ff <= 8'h00;
		end else if (wr_en & hit_ctrl) begin
			reloc_ff <= pwdata[`CTRL_RELOC_BIT];
			bod_en_ff <= pwdata[`CTRL_BOD_EN_BIT];
			rtc_en_ff <= pwdata[`CTRL_RTC_EN_BIT];
		end else if (wr_en & hit_mode & (pwdata[2:0] <= 3'h4)) begin
			mode_ff <= pwdata[2:0];
		end else if (wr_en & hit_pr) begin
			pr_ff <= pwdata[7:0];
		end
	end

	// Wake sources depend on the selected mode.
	assign wake_ok = (mode_sel == MODE_IDLE) ? irq_any
		: ((mode_sel == MODE_PSAVE) | (mode_sel == MODE_ESTBY))
		? (irq_async | (irq_rtc & rtc_en_ff))
		: irq_async;

	always_comb begin
		nxt_pst = pst_ff;
		case (pst_ff)
			ST_ACTIVE: if (sleep_instr) nxt_pst = ST_SLEEP;
			ST_SLEEP: if (wake_ok) nxt_pst = ST_HALT;
			ST_HALT: if (halt_cnt_ff == `WAKE_HALT_CYC - 3'h1)
				nxt_pst = ST_ACTIVE;
			default: nxt_pst = ST_ACTIVE;
		endcase
	end

	// Interrupt dispatch and resume point stay with the core and its
	// controller; this block only releases the halt, so pending higher
	// priority handlers run first and return lands after sleep.
	always_ff @(posedge pclk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			pst_ff <= ST_ACTIVE;
			halt_cnt_ff <= 3'h0;
		end else begin
			pst_ff <= nxt_pst;
			halt_cnt_ff <= (pst_ff == ST_HALT) ? halt_cnt_ff + 3'h1 : 3'h0;
		end
	end

	wire asleep = pst_ff == ST_SLEEP;
	assign cpu_halt = ~core_rst_n | (pst_ff != ST_ACTIVE) | swrst_ff;
	assign cpu_clk_en = core_rst_n & ~asleep;
	assign nvm_clk_en = core_rst_n & (~asleep | nvm_busy);
	assign periph_clk_en = core_rst_n & (~asleep | mode_sel == MODE_IDLE);
	assign periph_gate_en = {`NUM_PERIPH{periph_clk_en}} & ~pr_ff;
	assign rtc_clk_en = rtc_en_ff & (~asleep | mode_sel == MODE_IDLE
		| mode_sel == MODE_PSAVE | mode_sel == MODE_ESTBY);
	assign osc_src_en = ~asleep | mode_sel == MODE_IDLE
		| mode_sel == MODE_STBY | mode_sel == MODE_ESTBY;

	// Bus answers in the access cycle; cause survives core reset, the status power state does not.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= 32'h0;
		end else if (psel & ~penable) begin
			if (hit_ctrl) rdata_ff <= {28'h0, rtc_en_ff, bod_en_ff, reloc_ff, 1'b0};
			else if (hit_mode) rdata_ff <= {29'h0, mode_ff};
			else if (hit_pr) rdata_ff <= {24'h0, pr_ff};
			else if (hit_cause) rdata_ff <= {26'h0, cause_ff};
			else if (hit_stat) rdata_ff <= {26'h0, stage_ff, pst_ff, core_rst_n,
				brownout_detector_en};
			else rdata_ff <= 32'h0;
		end
	end

	assign prdata = rdata_ff;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	wire unused_rd = rd_en;
endmodule // sleep_and_reset_controller

// ===== pkg/sleep_reset_defs.svh
`ifndef SLEEP_RESET_DEFS_SVH
`define SLEEP_RESET_DEFS_SVH
`define OFS_CTRL         12'h000
`define OFS_MODE         12'h004
`define OFS_PWR_RED      12'h008
`define OFS_CAUSE        12'h00c
`define OFS_STATUS       12'h010
`define OFS_WAKE_EN      12'h014
`define CTRL_SWRST_BIT   0
`define CTRL_RELOC_BIT   1
`define CTRL_BOD_EN_BIT  2
`define CTRL_RTC_EN_BIT  3
`define MODE_W           3
`define NUM_PERIPH       8
`define NUM_CAUSE        6
`define CAUSE_POR        0
`define CAUSE_EXT        1
`define CAUSE_WDT        2
`define CAUSE_BOD        3
`define CAUSE_DBG        4
`define CAUSE_SW         5
`define WAKE_HALT_CYC    3'h4
`define EXT_MIN_NS       100
`define RST_DELAY_NS     1000
`define OSC_START_NS     2000
`define OSC_CAL_NS       500
`define CLK_NS           20
`define RESET_VEC_DEF    16'h0000
`define BOOT_VEC_DEF     16'h8000
`define BOD_LOWEST       3'h0
`endif

// ===== pkg/sleep_reset_pkg.sv
package sleep_reset_pkg;
	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_PDOWN,
		MODE_PSAVE,
		MODE_STBY,
		MODE_ESTBY
	} sleep_mode_type;
	typedef enum logic [1:0] {
		ST_ACTIVE,
		ST_SLEEP,
		ST_HALT
	} pwr_state_type;
	typedef enum logic [1:0] {
		RS_DELAY,
		RS_OSC,
		RS_CAL,
		RS_RUN
	} rst_stage_type;
endpackage

// ===== verif/core_model.sv
`timescale 1ns/1ns
module core_model (
	input  wire logic       pclk,
	input  wire logic       sleep_req,
	input  wire logic [2:0] irq_req,
	input  wire logic       cpu_halt,
	output logic            sleep_instr = 1'b0,
	output logic            irq_any,
	output logic            irq_async,
	output logic            irq_rtc
);
	logic [2:0] pend_ff = 3'h0;
	logic       halt_ff = 1'b0;
	// Requests stay pending until the handlers run once the halt ends.
	always_ff @(posedge pclk) begin
		sleep_instr <= sleep_req;
		halt_ff <= cpu_halt;
		if (halt_ff && !cpu_halt)
			pend_ff <= irq_req;
		else
			pend_ff <= pend_ff | irq_req;
	end
	assign irq_any   = |pend_ff;
	assign irq_async = pend_ff[1];
	assign irq_rtc   = pend_ff[2];
endmodule // core_model

// ===== verif/sleep_and_reset_controller_test.sv
`timescale 1ns/1ns
module sleep_and_reset_controller_test;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, por_n = 1'b0, ext_reset_n = 1'b1;
	logic        wdt_reset_req = 1'b0, bod_trip = 1'b0, dbg_reset_req = 1'b0;
	logic        chip_erase = 1'b0, debug_link_en = 1'b0, nvm_busy = 1'b0;
	logic        sleep_req = 1'b0, sleep_instr, irq_any, irq_async, irq_rtc;
	logic        pready, pslverr, cpu_halt, cpu_clk_en, nvm_clk_en, err, woke;
	logic        periph_clk_en, rtc_clk_en, osc_src_en, osc2m_sel, ulp_osc_en;
	logic        sys_reset_n, pin_oe_allow, brownout_detector_en;
	logic [2:0]  irq_req = 3'h0, brownout_threshold_select;
	logic [7:0]  periph_gate_en;
	logic [11:0] paddr = 12'h000;
	logic [15:0] reset_vector;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int          n_mismatch = 0, tests_run = 0, n;
	// Row: mode, interrupt kinds, wakes, then periph, rtc, osc clocks asleep.
	localparam logic [9:0] rows [6] = '{10'h01f, 10'h0c0, 10'h14a, 10'h1c1,
		10'h24b, 10'h0a8};
	always #10 pclk = ~pclk;
	sleep_and_reset_controller i_dut (.*);
	core_model i_core (.*);
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tmo;
		n_mismatch++;
		stop_test;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 50)
			tmo;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rst_wait;
		for (n = 0; n < 400; n++) begin
			@(posedge pclk);
			if (sys_reset_n === 1'b1)
				break;
		end
		if (n == 400)
			tmo;
	endtask
	task automatic go_sleep(input logic [2:0] m);
		apb(1'b1, 12'h004, {29'h0, m});
		@(posedge pclk);
		sleep_req <= 1'b1;
		@(posedge pclk);
		sleep_req <= 1'b0;
		repeat (3) @(negedge pclk);
	endtask
	task automatic wake(input logic [2:0] q);
		int i;
		@(posedge pclk);
		irq_req <= q;
		@(posedge pclk);
		irq_req <= 3'h0;
		woke = 1'b0;
		for (i = 0; i < 20 && !woke; i++) begin
			@(negedge pclk);
			woke = (cpu_halt === 1'b1) && (cpu_clk_en === 1'b1);
		end
		repeat (6) @(negedge pclk);
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		chk(32'({sys_reset_n, pin_oe_allow}), 32'h0);
		presetn <= 1'b1;
		por_n <= 1'b1;
		rst_wait;
		chk(32'(n > 171 && n < 184), 32'h1);
		chk(32'({osc2m_sel, ulp_osc_en, reset_vector}), 32'h3_0000);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, 12'h014, 32'hffff_ffff);
		apb(1'b1, 12'h000, 32'h8);
		apb(1'b1, 12'h008, 32'ha5);
		@(negedge pclk);
		chk(32'(periph_gate_en), 32'h5a);
		foreach (rows[k]) begin
			go_sleep(rows[k][9:7]);
			chk(32'({cpu_clk_en, periph_clk_en, rtc_clk_en, osc_src_en}),
				32'(rows[k][2:0]));
			wake(rows[k][6:4]);
			chk(32'(woke), 32'(rows[k][3]));
			if (!rows[k][3])
				wake(3'h2);
			chk(32'({cpu_halt, cpu_clk_en}), 32'h1);
		end
		@(posedge pclk);
		nvm_busy <= 1'b1;
		go_sleep(3'h0);
		chk(32'(nvm_clk_en), 32'h1);
		@(posedge pclk);
		nvm_busy <= 1'b0;
		repeat (3) @(negedge pclk);
		chk(32'(nvm_clk_en), 32'h0);
		wake(3'h1);
		apb(1'b0, 12'h040, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		for (int w = 3; w < 13; w += 9) begin
			@(posedge pclk);
			ext_reset_n <= 1'b0;
			repeat (w) @(posedge pclk);
			@(negedge pclk);
			chk(32'(sys_reset_n), 32'(w == 3));
			@(posedge pclk);
			ext_reset_n <= 1'b1;
		end
		rst_wait;
		go_sleep(3'h1);
		wdt_reset_req <= 1'b1;
		repeat (30) @(posedge pclk);
		wdt_reset_req <= 1'b0;
		repeat (100) @(posedge pclk);
		{bod_trip, dbg_reset_req} <= 2'h3;
		@(posedge pclk);
		{bod_trip, dbg_reset_req} <= 2'h0;
		rst_wait;
		chk(32'(n > 171 && n < 184), 32'h1);
		chk(32'({cpu_halt, cpu_clk_en}), 32'h1);
		apb(1'b1, 12'h000, 32'h2);
		@(negedge pclk);
		chk(32'(reset_vector), 32'h8000);
		apb(1'b1, 12'h000, 32'h1);
		repeat (3) @(posedge pclk);
		rst_wait;
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h3f);
		chip_erase <= 1'b1;
		@(negedge pclk);
		chk(32'({brownout_detector_en, brownout_threshold_select}), 32'h8);
		stop_test;
	end
endmodule // sleep_and_reset_controller_test

// ===== verif/sleep_reset_monitor.sv
`timescale 1ns/1ns
module sleep_reset_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        por_n,
	input wire logic        ext_reset_n,
	input wire logic        wdt_reset_req,
	input wire logic        bod_trip,
	input wire logic        dbg_reset_req,
	input wire logic        chip_erase,
	input wire logic        debug_link_en,
	input wire logic        sleep_instr,
	input wire logic        nvm_busy,
	input wire logic        cpu_halt,
	input wire logic        cpu_clk_en,
	input wire logic        osc2m_sel,
	input wire logic        ulp_osc_en,
	input wire logic        sys_reset_n,
	input wire logic        pin_oe_allow,
	input wire logic        brownout_detector_en,
	input wire logic [2:0]  brownout_threshold_select
);
	logic [8:0] quiet_ff;
	wire        src_on = !por_n || !ext_reset_n || wdt_reset_req || bod_trip
		|| dbg_reset_req;
	wire        swrst_wr = psel && penable && pwrite && sys_reset_n
		&& paddr == 12'h000 && pwdata[0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Saturates, so a long quiet spell never wraps back under the limit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn || src_on)
			quiet_ff <= 9'h000;
		else if (quiet_ff != 9'h1ff)
			quiet_ff <= quiet_ff + 9'h001;
	end
	a_src_forces_reset: assert property (bod_trip || dbg_reset_req
		|-> !sys_reset_n)
		else $error("reset source ignored");
	a_pins_tristated: assert property (!sys_reset_n |-> !pin_oe_allow)
		else $error("pins driven in reset");
	a_release_waits: assert property ($rose(sys_reset_n) |-> quiet_ff >= 9'haa)
		else $error("reset released early");
	a_swrst_two_cycles: assert property (swrst_wr |-> ##[1:2] !sys_reset_n)
		else $error("software reset late");
	a_wake_halt_four: assert property ($rose(cpu_halt && cpu_clk_en)
		|-> (cpu_halt && cpu_clk_en) [*4] ##1 !cpu_halt)
		else $error("halt not four cycles");
	a_sleep_stops_cpu: assert property (sleep_instr && cpu_clk_en && !cpu_halt
		&& !nvm_busy && sys_reset_n |=> !cpu_clk_en)
		else $error("cpu clock kept in sleep");
	a_bod_forced_low: assert property (chip_erase || debug_link_en
		|-> brownout_detector_en && brownout_threshold_select == 3'h0)
		else $error("brownout not forced low");
	a_boot_clock: assert property ($rose(sys_reset_n) |-> osc2m_sel && ulp_osc_en)
		else $error("boot clock wrong");
endmodule // sleep_reset_monitor
bind sleep_and_reset_controller sleep_reset_monitor i_mon (.*);
